// File: design/ebw_pkg.sv
package ebw_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [1:0] EBW_ADDR_CTRL     = 2'h0;
    localparam logic [1:0] EBW_ADDR_CSCTRL   = 2'h1;
    localparam logic [1:0] EBW_ADDR_STATUS   = 2'h2;
    localparam logic [7:0] EBW_CTRL_RESET    = 8'h00;
    localparam logic [7:0] EBW_CSCTRL_RESET  = 8'h33;
    // Control register fields
    localparam int EBW_BIT_VIS      = 7;
    localparam int EBW_BIT_MODE     = 6;
    localparam int EBW_BIT_SRC      = 5;
    localparam int EBW_POS_STROBE   = 2;
    localparam int EBW_POS_SPLIT    = 0;
    // Chip-select register fields
    localparam int EBW_POS_HIWS     = 4;
    localparam int EBW_POS_LOWS     = 0;
    // Region boundaries
    localparam logic [15:0] EBW_SPLIT_0 = 16'h1000;
    localparam logic [15:0] EBW_SPLIT_1 = 16'h4000;
    localparam logic [15:0] EBW_SPLIT_2 = 16'h8000;
    localparam logic [15:0] EBW_SPLIT_3 = 16'hC000;
    // Strobe select codes
    localparam logic [1:0] EBW_STB_OFF  = 2'h0;
    localparam logic [1:0] EBW_STB_LOW  = 2'h1;
    typedef enum logic [3:0] {
        EBW_IDLE  = 4'b0001,
        EBW_PHASE = 4'b0010,
        EBW_WAIT  = 4'b0100,
        EBW_DONE  = 4'b1000
    } ebw_state_t;
endpackage

// File: design/ebw_top.sv
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module ebw_top (
    // Clock and reset
    input  wire logic                      clock_in,
    input  wire logic                      sys_rst_in,
    // Register port
    input  wire logic [1:0]                reg_addr_in,
    input  wire logic [7:0]                reg_wdata_in,
    input  wire logic                      reg_wr_in,
    input  wire logic                      reg_rd_in,
    output logic      [7:0]                reg_rdata_out,
    // Internal bus cycle
    input  wire logic                      cyc_start_in,
    input  wire logic [15:0]               cyc_addr_in,
    input  wire logic                      cyc_read_in,
    input  wire logic                      cyc_internal_in,
    input  wire logic [7:0]                cyc_wdata_in,
    output logic      [7:0]                cyc_rdata_out,
    output logic                           wait_request_out,
    output logic                           cyc_done_out,
    // External pins
    output logic      [15:0]               ext_addr_out,
    output logic      [7:0]                ext_data_out,
    output logic      [7:0]                ext_data_oe_n_out,
    input  wire logic [7:0]                ext_data_in,
    output logic                           low_region_select_n_out,
    output logic                           high_region_select_n_out,
    output logic                           external_read_strobe_n_out,
    output logic                           external_write_strobe_n_out,
    output logic                           wait_strobe_pin_out,
    output logic                           wait_strobe_pin_oe_n_out
);
    import ebw_pkg::*;

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0]  ctrl_q;
    logic [7:0]  csctrl_q;
    ebw_state_t  state_q;
    logic [15:0] addr_q;
    logic        read_q;
    logic        int_q;
    logic [7:0]  wdata_q;
    logic [2:0]  wcnt_q;
    logic [2:0]  last_wait_q;

    function automatic logic [15:0] split_addr(input logic [1:0] code);
        case (code)
            2'h0:    split_addr = EBW_SPLIT_0;
            2'h1:    split_addr = EBW_SPLIT_1;
            2'h2:    split_addr = EBW_SPLIT_2;
            default: split_addr = EBW_SPLIT_3;
        endcase
    endfunction

    logic       vis;
    logic       low_noise;
    logic [1:0] stb_sel;
    logic       ext_wait_en;
    logic       in_low;
    logic       active;
    logic       low_sel;
    logic       phase4;
    logic [2:0] wait_sel;

    assign vis         = ctrl_q[EBW_BIT_VIS];
    assign low_noise   = ctrl_q[EBW_BIT_MODE];
    assign stb_sel     = ctrl_q[EBW_POS_STROBE +: 2];
    assign ext_wait_en = ctrl_q[EBW_BIT_SRC] && (stb_sel != EBW_STB_OFF);
    assign in_low      = addr_q < split_addr(ctrl_q[EBW_POS_SPLIT +: 2]);
    assign active      = (state_q != EBW_IDLE) && (!int_q || vis);
    assign low_sel     = active && in_low && !int_q;
    assign phase4      = (state_q == EBW_PHASE);

    // Wait count settled in the fourth phase
    always_comb
    begin
        if (ext_wait_en && low_sel)
            wait_sel = ext_data_in[2:0];
        else if (in_low)
            wait_sel = {1'b0, csctrl_q[EBW_POS_LOWS +: 2]};
        else
            wait_sel = {1'b0, csctrl_q[EBW_POS_HIWS +: 2]};
    end

    // ****************************************
    // Register port
    // ****************************************
    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            ctrl_q   <= EBW_CTRL_RESET;
            csctrl_q <= EBW_CSCTRL_RESET;
        end
        else if (reg_wr_in)
        begin
            if (reg_addr_in == EBW_ADDR_CTRL)
                ctrl_q <= reg_wdata_in;
            if (reg_addr_in == EBW_ADDR_CSCTRL)
                csctrl_q <= reg_wdata_in;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
            reg_rdata_out <= 8'h00;
        else if (reg_rd_in)
        begin
            case (reg_addr_in)
                EBW_ADDR_CTRL:   reg_rdata_out <= ctrl_q;
                EBW_ADDR_CSCTRL: reg_rdata_out <= csctrl_q;
                EBW_ADDR_STATUS: reg_rdata_out <= {4'h0, wait_request_out, last_wait_q};
                default:         reg_rdata_out <= 8'h00;
            endcase
        end
        else
            reg_rdata_out <= 8'h00;
    end

    // ****************************************
    // Bus cycle sequencer
    // ****************************************
    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            state_q     <= EBW_IDLE;
            addr_q      <= 16'h0000;
            read_q      <= 1'b0;
            int_q       <= 1'b1;
            wdata_q     <= 8'h00;
            wcnt_q      <= 3'h0;
            last_wait_q <= 3'h0;
        end
        else
        begin
            case (state_q)
                EBW_IDLE:
                begin
                    if (cyc_start_in)
                    begin
                        addr_q  <= cyc_addr_in;
                        read_q  <= cyc_read_in;
                        int_q   <= cyc_internal_in;
                        wdata_q <= cyc_wdata_in;
                        state_q <= EBW_PHASE;
                    end
                end
                EBW_PHASE:
                begin
                    if (int_q)
                    begin
                        wcnt_q  <= 3'h0;
                        state_q <= EBW_DONE;
                    end
                    else
                    begin
                        wcnt_q      <= wait_sel;
                        last_wait_q <= wait_sel;
                        state_q     <= (wait_sel == 3'h0) ? EBW_DONE : EBW_WAIT;
                    end
                end
                EBW_WAIT:
                begin
                    wcnt_q <= wcnt_q - 3'h1;
                    if (wcnt_q == 3'h1)
                        state_q <= EBW_DONE;
                end
                EBW_DONE:
                    state_q <= EBW_IDLE;
                default:
                    state_q <= EBW_IDLE;
            endcase
        end
    end

    assign wait_request_out = (state_q == EBW_WAIT);
    assign cyc_done_out     = (state_q == EBW_DONE);

    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
            cyc_rdata_out <= 8'h00;
        else if ((state_q == EBW_DONE) && read_q && !int_q)
            cyc_rdata_out <= ext_data_in;
    end

    // ****************************************
    // External pins
    // ****************************************
    logic drive_now;
    assign drive_now = !low_noise || (state_q != EBW_IDLE && (!int_q || vis));

    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            ext_addr_out <= 16'h0000;
            ext_data_out <= 8'h00;
        end
        else if (drive_now)
        begin
            ext_addr_out <= addr_q;
            ext_data_out <= wdata_q;
        end
    end

    // Data drivers: off in phase four, and on reads
    always_comb
    begin
        if (phase4 || state_q == EBW_IDLE || read_q || !active)
            ext_data_oe_n_out = 8'hFF;
        else
            ext_data_oe_n_out = 8'h00;
        if (low_noise && state_q == EBW_IDLE)
            ext_data_oe_n_out = 8'h00;
        if (ext_wait_en && state_q == EBW_IDLE)
            ext_data_oe_n_out[2:0] = 3'h7;
    end

    assign low_region_select_n_out     = !low_sel;
    assign high_region_select_n_out    = !(active && !in_low);
    assign external_read_strobe_n_out  = !(active && read_q && !phase4);
    assign external_write_strobe_n_out = !(active && !read_q && !phase4);

    // Wait strobe pin, active low
    always_comb
    begin
        wait_strobe_pin_oe_n_out = 1'b0;
        case (stb_sel)
            EBW_STB_OFF:
            begin
                wait_strobe_pin_out      = 1'b1;
                wait_strobe_pin_oe_n_out = 1'b1;
            end
            EBW_STB_LOW:
                wait_strobe_pin_out = !(phase4 && low_sel);
            default:
                wait_strobe_pin_out = !(phase4 && !int_q);
        endcase
    end

    // ****************************************
    // Check helpers
    // ****************************************
    logic [3:0] wait_seen_q;

    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in || cyc_done_out)
            wait_seen_q <= 4'h0;
        else if (wait_request_out)
            wait_seen_q <= wait_seen_q + 4'h1;
    end

    // ****************************************
    // Checks
    // ****************************************
    AST_NO_INT_WAIT: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (phase4 && int_q) |=> !wait_request_out)
        else $error("wait request on internal cycle");
    AST_NO_INT_LOWSEL: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        int_q |-> low_region_select_n_out)
        else $error("low select on internal cycle");
    AST_T4_UNDRIVEN: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        phase4 |-> (ext_data_oe_n_out == 8'hFF))
        else $error("data driven in phase four");
    AST_EXT_COUNT: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (phase4 && ext_wait_en && low_sel) |=> (last_wait_q == $past(ext_data_in[2:0])))
        else $error("external wait count not taken");
    AST_HI_COUNT: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (phase4 && !int_q && !in_low) |=> (last_wait_q == {1'b0, $past(csctrl_q[EBW_POS_HIWS +: 2])}))
        else $error("high region count wrong");
    AST_WAIT_LEN3: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (phase4 && !int_q && wait_sel == 3'h3) |=> wait_request_out [*3] ##1 !wait_request_out)
        else $error("wait length wrong");
    AST_STB_OFF: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (stb_sel == EBW_STB_OFF) |-> wait_strobe_pin_oe_n_out)
        else $error("strobe pin driven when off");
    AST_STB_LOW: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (stb_sel == EBW_STB_LOW && !wait_strobe_pin_out) |-> (phase4 && !low_region_select_n_out))
        else $error("combined strobe wrong");
    AST_NO_VIS: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (int_q && !vis) |-> (external_read_strobe_n_out && external_write_strobe_n_out))
        else $error("strobe on hidden internal cycle");
    AST_RST_CONFIG: assert property (@(posedge clock_in)
        sys_rst_in |=> ((csctrl_q == EBW_CSCTRL_RESET) && !ctrl_q[EBW_BIT_SRC]))
        else $error("reset configuration wrong");
    AST_SPLIT_LOW: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (ctrl_q[EBW_POS_SPLIT +: 2] == 2'h0 && !low_region_select_n_out) |-> (addr_q < EBW_SPLIT_0))
        else $error("low select outside its region");
    AST_SPLIT_HIGH: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (ctrl_q[EBW_POS_SPLIT +: 2] == 2'h3 && !high_region_select_n_out) |-> (addr_q >= EBW_SPLIT_3))
        else $error("high select outside its region");
    AST_ONE_SELECT: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        !low_region_select_n_out |-> high_region_select_n_out)
        else $error("both selects active");
    AST_NO_INT_PIN: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (int_q && phase4) |-> (wait_strobe_pin_out || wait_strobe_pin_oe_n_out))
        else $error("wait strobe on internal cycle");
    AST_STB_PHASE: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (stb_sel[1] && !int_q) |-> (wait_strobe_pin_out == !phase4))
        else $error("plain phase strobe wrong");
    AST_WAIT_ZERO: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (phase4 && !int_q && wait_sel == 3'h0) |=> cyc_done_out)
        else $error("zero wait cycle not done");
    AST_WAIT_LEN1: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (phase4 && !int_q && wait_sel == 3'h1) |=> wait_request_out ##1 cyc_done_out)
        else $error("one wait cycle wrong");
    AST_WAIT_LEN2: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (phase4 && !int_q && wait_sel == 3'h2) |=> wait_request_out [*2] ##1 cyc_done_out)
        else $error("two wait cycles wrong");
    AST_WAIT_LEN7: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (phase4 && !int_q && wait_sel == 3'h7) |=> wait_request_out [*7] ##1 cyc_done_out)
        else $error("seven wait cycles wrong");
    AST_WAIT_TOTAL: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (cyc_done_out && !int_q) |-> (wait_seen_q == {1'b0, last_wait_q}))
        else $error("wait cycle total wrong");
    AST_DONE_PULSE: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        cyc_done_out |=> !cyc_done_out)
        else $error("done longer than one cycle");
    AST_INT_DONE: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (phase4 && int_q) |=> cyc_done_out)
        else $error("internal cycle stalled");
    AST_SRC_INTERNAL: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (phase4 && !int_q && in_low && !ext_wait_en) |=>
            (last_wait_q == {1'b0, $past(csctrl_q[EBW_POS_LOWS +: 2])}))
        else $error("low region internal count wrong");
    AST_LN_HOLD: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (low_noise && state_q == EBW_IDLE) |=> ($stable(ext_addr_out) && $stable(ext_data_out)))
        else $error("pins changed between accesses");
    AST_LN_IDLE_DRIVE: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (low_noise && state_q == EBW_IDLE) |-> (ext_data_oe_n_out[7:3] == 5'h00))
        else $error("held data lines released");
    AST_HP_DRIVE: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        !low_noise |=> ((ext_addr_out == $past(addr_q)) && (ext_data_out == $past(wdata_q))))
        else $error("pins not following cycle");
    AST_D20_RELEASE: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (ext_wait_en && state_q == EBW_IDLE) |-> (ext_data_oe_n_out[2:0] == 3'h7))
        else $error("low data lines held");
    AST_STROBES_EXCL: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        !external_read_strobe_n_out |-> external_write_strobe_n_out)
        else $error("read and write strobes together");
endmodule

// File: sim/ebw_ext_model.sv
`timescale 1ns/1ps
module ebw_ext_model (
    // Clock
    input  wire logic       clock_in,
    // Device pins
    input  wire logic       wait_strobe_pin_in,
    input  wire logic       wait_strobe_oe_n_in,
    input  wire logic       read_strobe_n_in,
    // Far side setup
    input  wire logic [2:0] wait_value_in,
    input  wire logic [7:0] read_value_in,
    // Data bus
    output logic      [7:0] ext_data_out
);
    // ****************************************
    // Buffers on the external data bus
    // ****************************************
    logic [7:0] noise_q = 8'h3C;
    always_ff @(posedge clock_in)
    begin
        noise_q <= noise_q + 8'h5B;
    end
    always_comb
    begin
        if (!wait_strobe_oe_n_in && !wait_strobe_pin_in)
            ext_data_out = {noise_q[7:3], wait_value_in};
        else if (!read_strobe_n_in)
            ext_data_out = read_value_in;
        else
            ext_data_out = noise_q;
    end
endmodule

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
    import ebw_pkg::*;
    logic clock_in, sys_rst_in, reg_wr, reg_rd, cyc_start, cyc_read, cyc_int;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, cyc_wdata, reg_rdata, cyc_rdata, ext_dout, ext_oe_n, ext_din, d;
    logic [15:0] cyc_addr, ext_addr;
    logic wreq, done, lo_n, hi_n, rs_n, ws_n, pin, pin_oe_n;
    logic [7:0] ctrl_m, cs_m;
    logic [2:0] ext_wait;
    logic [31:0] seed;
    int num_errors, n_checks;
    // ****************************************
    // Design and far side
    // ****************************************
    ebw_top dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
        .cyc_start_in(cyc_start), .cyc_addr_in(cyc_addr), .cyc_read_in(cyc_read),
        .cyc_internal_in(cyc_int), .cyc_wdata_in(cyc_wdata), .cyc_rdata_out(cyc_rdata),
        .wait_request_out(wreq), .cyc_done_out(done), .ext_addr_out(ext_addr),
        .ext_data_out(ext_dout), .ext_data_oe_n_out(ext_oe_n), .ext_data_in(ext_din),
        .low_region_select_n_out(lo_n), .high_region_select_n_out(hi_n),
        .external_read_strobe_n_out(rs_n), .external_write_strobe_n_out(ws_n),
        .wait_strobe_pin_out(pin), .wait_strobe_pin_oe_n_out(pin_oe_n));
    ebw_ext_model far (.clock_in(clock_in), .wait_strobe_pin_in(pin), .wait_strobe_oe_n_in(pin_oe_n),
        .read_strobe_n_in(rs_n), .wait_value_in(ext_wait), .read_value_in(seed[15:8]),
        .ext_data_out(ext_din));
    // ****************************************
    // Model, bus tasks and checks
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic is_low(input logic [15:0] a);
        return int'(a) < ((ctrl_m[1:0] == 2'h0) ? 32'h1000 : int'(ctrl_m[1:0]) * 32'h4000);
    endfunction
    function automatic int exp_waits(input logic [15:0] a, input logic intl);
        if (intl)
            return 0;
        if (is_low(a))
            return (ctrl_m[5] && ctrl_m[3:2] != 2'h0) ? int'(ext_wait) : int'(cs_m[1:0]);
        return int'(cs_m[5:4]);
    endfunction
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clock_in);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        if (a == EBW_ADDR_CTRL)
            ctrl_m = v;
        if (a == EBW_ADDR_CSCTRL)
            cs_m = v;
        @(posedge clock_in);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge clock_in);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock_in);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic cyc(input logic [15:0] a, input logic r, input logic intl);
        int n, e;
        logic lo;
        e  = exp_waits(a, intl);
        lo = is_low(a) && !intl;
        seed = lfsr(seed);
        @(posedge clock_in);
        cyc_addr  <= a;
        cyc_read  <= r;
        cyc_int   <= intl;
        cyc_wdata <= seed[7:0];
        cyc_start <= 1'b1;
        @(posedge clock_in);
        cyc_start <= 1'b0;
        #1;
        check("data_oe_n", ext_oe_n, 16'hFF);
        check("low_sel_n", lo_n, !lo);
        check("high_sel_n", hi_n, !(!is_low(a) && (!intl || ctrl_m[7])));
        check("pin_oe_n", pin_oe_n, ctrl_m[3:2] == EBW_STB_OFF);
        if (ctrl_m[3:2] != EBW_STB_OFF)
            check("pin", pin, (ctrl_m[3:2] == EBW_STB_LOW) ? !lo : intl);
        n = 0;
        for (int t = 0; t < 20; t++)
        begin
            @(posedge clock_in);
            #1;
            if (t == 0)
            begin
                check("strobe_n", r ? rs_n : ws_n, intl && !ctrl_m[7]);
                check("data_oe_n", ext_oe_n, (r || (intl && !ctrl_m[7])) ? 16'hFF : 16'h00);
                if (!r && !intl)
                    check("wdata", ext_dout, seed[7:0]);
            end
            if (done === 1'b1)
                break;
            if (wreq === 1'b1)
                n++;
        end
        check("waits", n, e);
        if (r && !intl)
        begin
            @(posedge clock_in);
            #1;
            check("rdata", cyc_rdata, seed[15:8]);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ****************************************
    // Clock, reset and tests
    // ****************************************
    initial
    begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    initial
    begin
        #300000;
        num_errors++;
        results;
    end
    initial
    begin
        {reg_wr, reg_rd, cyc_start, cyc_read, cyc_int} = 5'h00;
        {reg_addr, reg_wdata, cyc_wdata, cyc_addr, ext_wait} = '0;
        {num_errors, n_checks} = '0;
        seed = 32'h68fa;
        ctrl_m = 8'h00;
        cs_m = 8'h33;
        sys_rst_in = 1'b1;
        repeat (16) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        rd(EBW_ADDR_CTRL, d);
        check("ctrl", d, EBW_CTRL_RESET);
        rd(EBW_ADDR_CSCTRL, d);
        check("cs_ctrl", d, 16'h33);
        wr(2'h3, 8'hFF);
        rd(2'h3, d);
        check("unmapped", d, 16'h00);
        cyc(16'h0200, 1'b1, 1'b0);
        cyc(16'hF000, 1'b0, 1'b0);
        $display("test reset done");
        for (int c = 0; c < 4; c++)
        begin
            wr(EBW_ADDR_CSCTRL, 8'(c * 17));
            cyc(16'hE000, c[0], 1'b0);
        end
        $display("test high region done");
        wr(EBW_ADDR_CSCTRL, 8'h21);
        for (int s = 0; s < 4; s++)
        begin
            wr(EBW_ADDR_CTRL, 8'(8 + s));
            cyc((s == 0) ? 16'h0FFF : 16'(s * 16'h4000 - 1), 1'b1, 1'b0);
            cyc((s == 0) ? 16'h1000 : 16'(s * 16'h4000), 1'b0, 1'b0);
        end
        $display("test split done");
        for (int k = 0; k < 8; k++)
        begin
            seed = lfsr(seed);
            ext_wait = 3'(k);
            wr(EBW_ADDR_CTRL, k[0] ? 8'h69 : 8'h65);
            cyc({2'b00, seed[13:0]}, seed[14], 1'b0);
            rd(EBW_ADDR_STATUS, d);
            check("last_waits", d[2:0], 16'(k));
            cyc(16'hD000, 1'b1, 1'b0);
        end
        ext_wait = 3'h6;
        wr(EBW_ADDR_CTRL, 8'h21);
        cyc(16'h0800, 1'b1, 1'b0);
        wr(EBW_ADDR_CTRL, 8'h05);
        cyc(16'h0800, 1'b0, 1'b0);
        $display("test external waits done");
        for (int v = 0; v < 2; v++)
        begin
            wr(EBW_ADDR_CTRL, v[0] ? 8'h85 : 8'h05);
            cyc(16'h0400, 1'b1, 1'b1);
            cyc(16'hF800, 1'b0, 1'b1);
        end
        $display("test internal done");
        wr(EBW_ADDR_CTRL, 8'h65);
        cyc(16'h1234, 1'b0, 1'b0);
        cyc(16'h0050, 1'b1, 1'b1);
        repeat (2) @(posedge clock_in);
        #1;
        check("idle_oe_n", ext_oe_n, 16'h07);
        check("idle_addr", ext_addr, 16'h1234);
        wr(EBW_ADDR_CTRL, 8'h45);
        cyc(16'h0321, 1'b0, 1'b0);
        repeat (2) @(posedge clock_in);
        #1;
        check("idle_oe_n", ext_oe_n, 16'h00);
        check("idle_addr", ext_addr, 16'h0321);
        $display("test low noise done");
        results;
    end
endmodule
